// [wake_event_signalling_tb.sv]
`timescale 1ns/1ps
module wake_event_signalling_tb;
  import wes_pkg::*;
  localparam int PULSE = 20;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        energy_event, frame_event, energy_src_active, frame_src_active;
  logic        wake_pin_o, wake_pin_oe, wake_irq, device_ready;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, power_state, s;
  logic [2:0]  hsize;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cnt;

  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  wes_host_bfm host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  wes_wake_ctrl #(.PULSE_CYCLES(PULSE), .STABLE_CYCLES(4)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .energy_event(energy_event), .frame_event(frame_event), .energy_src_active(energy_src_active),
    .frame_src_active(frame_src_active), .wake_pin_o(wake_pin_o), .wake_pin_oe(wake_pin_oe),
    .wake_irq(wake_irq), .power_state(power_state), .device_ready(device_ready));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  task automatic ev(input logic en, input logic fr);
    @(posedge hclk);
    energy_event <= en;
    frame_event  <= fr;
    @(posedge hclk);
    energy_event <= 1'b0;
    frame_event  <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge hclk);
  endtask

  task give_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    n_errors++;
    give_verdict;
  end

  initial begin
    hresetn = 1'b0;
    energy_event = 1'b0;
    frame_event = 1'b0;
    energy_src_active = 1'b0;
    frame_src_active = 1'b0;
    wt(6);
    chk("pin_oe_rst", 0, wake_pin_oe);
    chk("irq_rst", 0, wake_irq);
    @(posedge hclk);
    hresetn <= 1'b1;
    host.rd(A_PWR_CTL, q);
    chk("ready_bit_early", 0, q[F_RDY]);
    host.wait_ready;
    chk("device_ready", 1, device_ready);
    host.rd(A_INT_STS, q);
    chk("int_ready", 1, q[INT_READY]);
    host.rd(A_INT_STS, q);
    chk("int_cleared", 0, q);
    host.rd(A_BYTE_TEST, q);
    chk("byte_test", BYTE_TEST_V, q);
    chk("hresp", 0, hresp);
    host.wr(A_HARDWARE_CONFIG_REGISTER, 32'hA5A5_0F0F);
    host.rd(A_HARDWARE_CONFIG_REGISTER, q);
    chk("hardware_config_register", 32'hA5A5_0F0F, q);
    host.rd(8'hA0, q);
    chk("unmapped", 0, q);
    // static, push-pull, active high, both enables
    host.wr(A_PWR_CTL, 32'h0000_0346);
    @(posedge hclk);
    energy_src_active <= 1'b1;
    frame_src_active  <= 1'b1;
    ev(1'b1, 1'b0);
    wt(3);
    chk("pin_static", 1, wake_pin_o);
    chk("pin_oe", 1, wake_pin_oe);
    chk("irq_masked", 0, wake_irq);
    host.wr(A_INT_MASK, 32'h1);
    wt(1);
    chk("irq", 1, wake_irq);
    host.rd(A_PWR_CTL, q);
    chk("cause_energy", WCS_ENERGY, q[5:4]);
    ev(1'b0, 1'b1);
    wt(2);
    host.rd(A_PWR_CTL, q);
    chk("cause_multi", WCS_MULTI, q[5:4]);
    host.wr(A_PWR_CTL, 32'h0000_0376);
    host.rd(A_PWR_CTL, q);
    chk("cause_held", WCS_MULTI, q[5:4]);
    @(posedge hclk);
    energy_src_active <= 1'b0;
    frame_src_active  <= 1'b0;
    host.wr(A_PWR_CTL, 32'h0000_0356);
    host.rd(A_PWR_CTL, q);
    chk("cause_w1c", WCS_FRAME, q[5:4]);
    host.wr(A_PWR_CTL, 32'h0000_0366);
    wt(2);
    chk("pin_cleared", 0, wake_pin_o);
    host.rd(A_INT_STS, q);
    chk("int_wake", 1, q[INT_WAKE]);
    wt(1);
    chk("irq_read_clr", 0, wake_irq);
    // pulse mode, active low: exactly PULSE active cycles
    host.wr(A_PWR_CTL, 32'h0000_034A);
    ev(1'b1, 1'b0);
    cnt = 0;
    repeat (2 * PULSE) begin
      @(negedge hclk);
      if (wake_pin_o === 1'b0) cnt++;
    end
    chk("pulse_len", PULSE, cnt);
    host.wr(A_PWR_CTL, 32'h0000_035A);
    host.rd(A_INT_STS, q);
    // open drain ignores polarity; output enable does not gate the interrupt
    host.wr(A_PWR_CTL, 32'h0000_0306);
    ev(1'b0, 1'b1);
    wt(3);
    chk("od_level", 0, wake_pin_o);
    chk("od_oe", 1, wake_pin_oe);
    host.wr(A_PWR_CTL, 32'h0000_0304);
    wt(1);
    chk("oe_off", 0, wake_pin_oe);
    chk("irq_oe_off", 1, wake_irq);
    host.wr(A_PWR_CTL, 32'h0000_0034);
    host.rd(A_INT_STS, q);
    // sleep states, register access while asleep, wake by byte test write
    for (int i = 1; i < 4; i++) begin
      s = 2'(i);
      host.wr(A_PWR_CTL, {18'h0, s, 12'h0});
      wt(1);
      chk("pstate", (s == PSS_RSVD) ? PSS_FULL : s, power_state);
      if (s != PSS_RSVD) begin
        host.rd(A_PWR_CTL, q);
        chk("pstate_rd", s, q[13:12]);
        host.wake;
        host.wait_ready;
        chk("pstate_woke", PSS_FULL, power_state);
      end
    end
    give_verdict;
  end
endmodule

// [wes_host_bfm.sv]
`timescale 1ns/1ps
module wes_host_bfm
  import wes_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // one single word transfer; the released data bus shows the inverse so stale data never matches
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask

  // only the power control register is touched until ready shows
  task automatic wait_ready;
    logic [31:0] q;
    do rd(A_PWR_CTL, q); while (q[F_RDY] !== 1'b1);
  endtask

  task automatic wake;
    wr(A_BYTE_TEST, 32'h0);
  endtask
endmodule

// [wes_pkg.sv]
package wes_pkg;
  // register byte addresses (low eight address bits)
  localparam logic [7:0]  A_BYTE_TEST = 8'h64;
  localparam logic [7:0]  A_HARDWARE_CONFIG_REGISTER    = 8'h74;
  localparam logic [7:0]  A_PWR_CTL   = 8'h84;
  localparam logic [7:0]  A_INT_STS   = 8'h90;
  localparam logic [7:0]  A_INT_MASK  = 8'h94;
  // power control field positions
  localparam int          F_PSS       = 12;
  localparam int          F_WFE       = 9;
  localparam int          F_EDE       = 8;
  localparam int          F_BUF       = 6;
  localparam int          F_WCS       = 4;
  localparam int          F_PULSE     = 3;
  localparam int          F_POL       = 2;
  localparam int          F_OE        = 1;
  localparam int          F_RDY       = 0;
  // wake cause codes
  localparam logic [1:0]  WCS_NONE    = 2'h0;
  localparam logic [1:0]  WCS_ENERGY  = 2'h1;
  localparam logic [1:0]  WCS_FRAME   = 2'h2;
  localparam logic [1:0]  WCS_MULTI   = 2'h3;
  // power state select codes
  localparam logic [1:0]  PSS_FULL    = 2'h0;
  localparam logic [1:0]  PSS_FRAME   = 2'h1;
  localparam logic [1:0]  PSS_ENERGY  = 2'h2;
  localparam logic [1:0]  PSS_RSVD    = 2'h3;
  // interrupt status bits
  localparam int          INT_WAKE    = 0;
  localparam int          INT_READY   = 1;
  localparam int          INT_W       = 2;
  // reset value and fixed byte test read pattern
  localparam logic [31:0] HARDWARE_CONFIG_REGISTER_RST  = 32'h0000_0000;
  localparam logic [31:0] BYTE_TEST_V = 32'h5A3C_C3A5; // arbitrary pattern
  // timing
  localparam int          CLK_HZ      = 50_000_000;
  localparam int          PULSE_MS    = 50;
  localparam int          PULSE_CYC   = PULSE_MS * (CLK_HZ / 1000);
  localparam int          STABLE_CYC  = 64;
  localparam int          CNT_W       = 22;
  typedef enum logic [1:0] {PH_STABLE, PH_RUN, PH_SLEEP} wes_phase_e;
endpackage

// [wes_pulse_timer.sv]
`timescale 1ns/1ps
module wes_pulse_timer #(
  parameter int W = 22,
  parameter int N = 2_500_000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic start,
  input  wire logic cancel,
  output logic      busy
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } wes_tmr_s;

  wes_tmr_s q;
  wes_tmr_s d;

  // busy stands exactly N cycles, starting the cycle after start
  always_comb begin
    d = q;
    if (cancel) begin
      d.cnt = '0;
    end else if (start) begin
      d.cnt = W'(N);
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = (q.cnt != '0);
endmodule

// [wes_wake_ctrl.sv]
`timescale 1ns/1ps
// What this block does
// - wake cause reads 00 none, 01 energy, 10 frame, 11 multiple
// - writing one clears a wake cause bit; zero leaves it
// - wake cause clears only when back at full power and ready
// - a clear takes effect only while its event source is idle
// - pulse select set gives one 50 ms wake output pulse
// - pulse select clear holds the wake output until deactivated
// - wake output drops when cause cleared or its enable cleared
// - polarity bit picks active high when set, low when clear
// - open-drain drive ignores polarity and is always active low
// - output enable gates only the pin, never the interrupt
// - ready bit sets once the device has stabilised
// - power control register stays readable in every power state
// - power state 00 full, 01 frame detect, 10 energy, 11 reserved
// - buffer type clear is open-drain, set is push-pull
// - enabled events raise the wake output, and the interrupt only when its mask bit is set
// - any write to byte test wakes a sleeping device
module wes_wake_ctrl
  import wes_pkg::*;
#(
  parameter int PULSE_CYCLES  = PULSE_CYC,
  parameter int STABLE_CYCLES = STABLE_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        energy_event,
  input  wire logic        frame_event,
  input  wire logic        energy_src_active,
  input  wire logic        frame_src_active,
  output logic             wake_pin_o,
  output logic             wake_pin_oe,
  output logic             wake_irq,
  output logic [1:0]       power_state,
  output logic             device_ready
);
  import wes_pkg::*;

  typedef struct packed {
    wes_phase_e        ph;
    logic [15:0]       stab;
    logic [1:0]        pss;
    logic              wfe;
    logic              ede;
    logic              buf_pp;
    logic              pulse;
    logic              pol;
    logic              oe;
    logic [1:0]        wcs;
    logic              act;
    logic [31:0]       hwcfg;
    logic [INT_W-1:0]  ists;
    logic [INT_W-1:0]  imask;
    logic              dp_wr;
    logic [7:0]        dp_addr;
    logic [31:0]       rdata;
    logic              irq;
    logic              pin_o;
    logic              pin_oe;
    logic              tstart;
    logic [CNT_W:0]    run;
    logic              rdy;
  } wes_state_s;

  wes_state_s q;
  wes_state_s d;
  logic       busy;
  logic       ap;
  logic       ev_e;
  logic       ev_f;
  logic       lvl;
  logic       wr_pwr;
  logic [1:0] clr;
  logic [31:0] rd;

  wes_pulse_timer #(
    .W (CNT_W),
    .N (PULSE_CYCLES)
  ) u_tmr (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (q.tstart),
    .cancel  (!q.act),
    .busy    (busy)
  );

  function automatic logic [1:0] merge(input logic [1:0] cur, input logic [1:0] ev);
    logic [1:0] r;
    r = cur;
    if (ev != WCS_NONE) begin
      if (cur == WCS_NONE) begin
        r = ev;
      end else if (cur != ev) begin
        r = WCS_MULTI;
      end
    end
    return r;
  endfunction

  always_comb begin
    d = q;
    d.tstart = 1'b0;
    clr = 2'h0;
    rd = 32'h0000_0000;
    ap = hsel & htrans[1] & hready;
    ev_e = energy_event & q.ede;
    ev_f = frame_event & q.wfe;
    wr_pwr = q.dp_wr & (q.dp_addr == A_PWR_CTL);
    // read data is fetched in the address phase so hrdata is a flop
    case (haddr[7:0])
      A_PWR_CTL: begin
        rd[F_PSS+:2] = q.pss;
        rd[F_WFE]    = q.wfe;
        rd[F_EDE]    = q.ede;
        rd[F_BUF]    = q.buf_pp;
        rd[F_WCS+:2] = q.wcs;
        rd[F_PULSE]  = q.pulse;
        rd[F_POL]    = q.pol;
        rd[F_OE]     = q.oe;
        rd[F_RDY]    = q.rdy;
      end
      A_HARDWARE_CONFIG_REGISTER:    rd = q.hwcfg;
      A_BYTE_TEST: rd = q.rdy ? BYTE_TEST_V : 32'h0000_0000;
      A_INT_STS:   rd = q.rdy ? 32'(q.ists) : 32'h0000_0000;
      A_INT_MASK:  rd = q.rdy ? 32'(q.imask) : 32'h0000_0000;
      default:     rd = 32'h0000_0000;
    endcase
    if (ap && !hwrite) begin
      d.rdata = rd;
      if (haddr[7:0] == A_INT_STS && q.rdy) begin
        d.ists = '0;
      end
    end
    d.dp_wr = ap & hwrite;
    d.dp_addr = haddr[7:0];
    // write data phase; before ready, mask writes, cause clears and power state changes are dropped
    if (q.dp_wr) begin
      case (q.dp_addr)
        A_PWR_CTL: begin
          d.wfe    = hwdata[F_WFE];
          d.ede    = hwdata[F_EDE];
          d.buf_pp = hwdata[F_BUF];
          d.pulse  = hwdata[F_PULSE];
          d.pol    = hwdata[F_POL];
          d.oe     = hwdata[F_OE];
          if (q.rdy) begin
            clr = hwdata[F_WCS+:2];
          end
          if (q.ph == PH_RUN && hwdata[F_PSS+:2] != PSS_FULL && hwdata[F_PSS+:2] != PSS_RSVD) begin
            d.pss = hwdata[F_PSS+:2];
            d.ph  = PH_SLEEP;
            d.rdy = 1'b0;
          end
        end
        A_HARDWARE_CONFIG_REGISTER: begin
          d.hwcfg = hwdata;
        end
        A_BYTE_TEST: begin
          if (q.ph == PH_SLEEP) begin
            d.pss  = PSS_FULL;
            d.ph   = PH_STABLE;
            d.stab = 16'(STABLE_CYCLES);
          end
        end
        A_INT_MASK: begin
          if (q.rdy) begin
            d.imask = hwdata[INT_W-1:0];
          end
        end
        default: ;
      endcase
    end
    // a cause bit whose source still reports an event cannot be cleared
    clr = clr & ~{frame_src_active, energy_src_active};
    d.wcs = q.wcs & ~clr;
    // events apply after the clear so a coincident event is kept
    d.wcs = merge(d.wcs, ev_e ? WCS_ENERGY : WCS_NONE);
    d.wcs = merge(d.wcs, ev_f ? WCS_FRAME : WCS_NONE);
    if (ev_e || ev_f) begin
      d.act = 1'b1;
      d.tstart = q.pulse;
      d.ists[INT_WAKE] = 1'b1;
    end else if (!((d.wcs[0] & d.ede) | (d.wcs[1] & d.wfe))) begin
      d.act = 1'b0;
    end
    case (q.ph)
      PH_STABLE: begin
        if (q.stab <= 16'h0001) begin
          d.stab = 16'h0000;
          d.ph   = PH_RUN;
          d.rdy  = 1'b1;
          d.ists[INT_READY] = 1'b1;
        end else begin
          d.stab = q.stab - 16'h0001;
        end
      end
      PH_RUN:   ;
      PH_SLEEP: ;
      default:  d.ph = PH_STABLE;
    endcase
    // static mode holds while active; pulse mode lasts the timer run
    lvl = q.act & (q.pulse ? busy : 1'b1);
    // consecutive pulse-mode active cycles, only watched by the pulse length check
    d.run = (q.act && q.pulse && busy) ? q.run + (CNT_W+1)'(1) : '0;
    if (d.buf_pp) begin
      d.pin_o  = d.pol ? lvl : ~lvl;
      d.pin_oe = d.oe;
    end else begin
      d.pin_o  = 1'b0;
      d.pin_oe = d.oe & lvl;
    end
    d.irq = |(d.ists & d.imask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q         <= '0;
      q.ph      <= PH_STABLE;
      q.stab    <= 16'(STABLE_CYCLES);
      q.hwcfg   <= HARDWARE_CONFIG_REGISTER_RST;
      q.pin_o   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata       = q.rdata;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign wake_pin_o   = q.pin_o;
  assign wake_pin_oe  = q.pin_oe;
  assign wake_irq     = q.irq;
  assign power_state  = q.pss;
  assign device_ready = q.rdy;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_cause_energy: assert property (ev_e && !ev_f && q.wcs == WCS_NONE |=> q.wcs == WCS_ENERGY)
    else $error("energy cause code wrong");
  a_cause_multi: assert property (ev_e && q.wcs == WCS_FRAME && !q.dp_wr
    |=> q.wcs == WCS_MULTI)
    else $error("multiple cause code missing");
  a_clear_gate: assert property (!q.rdy |=> (q.wcs & $past(q.wcs)) == $past(q.wcs))
    else $error("cause cleared while not ready");
  a_src_block: assert property (energy_src_active && q.wcs[0] |=> q.wcs[0])
    else $error("cause cleared while source active");
  a_pulse_len: assert property (q.run <= (CNT_W+1)'(PULSE_CYCLES))
    else $error("wake pulse too long");
  a_act_cause: assert property (q.act |-> q.wcs != WCS_NONE)
    else $error("wake active with no cause");
  a_od_low: assert property (!q.buf_pp && !q.dp_wr ##1 wake_pin_oe |-> !wake_pin_o)
    else $error("open drain drove high");
  a_oe_gate: assert property (!q.oe && !q.dp_wr |=> !wake_pin_oe)
    else $error("pin driven while disabled");
  a_irq_wake: assert property ((ev_e || ev_f) && q.imask[INT_WAKE] && !q.dp_wr |=> wake_irq)
    else $error("wake interrupt missing");
  a_byte_wake: assert property (q.dp_wr && q.dp_addr == A_BYTE_TEST && q.ph == PH_SLEEP
    |=> power_state == PSS_FULL && !device_ready)
    else $error("byte test write did not wake");
  a_pss_legal: assert property (power_state != PSS_RSVD)
    else $error("reserved power state");
  a_sleep_rdy: assert property (q.ph == PH_SLEEP |-> !device_ready)
    else $error("ready while asleep");
  // a coincident event may refill a cleared cause bit, so clears exclude the event
  a_cause_frame: assert property (ev_f && !ev_e && q.wcs == WCS_NONE
    |=> q.wcs == WCS_FRAME)
    else $error("frame cause code wrong");
  a_cause_both: assert property (ev_e && ev_f && q.wcs == WCS_NONE
    |=> q.wcs == WCS_MULTI)
    else $error("coincident causes not multiple");
  a_cause_sticky: assert property (q.wcs == WCS_MULTI && !q.dp_wr
    |=> q.wcs == WCS_MULTI)
    else $error("multiple cause lost");
  a_w1c_energy: assert property (wr_pwr && q.rdy && hwdata[F_WCS] && !energy_src_active && !ev_e
    |=> !q.wcs[0])
    else $error("energy cause not cleared");
  a_w1c_frame: assert property (wr_pwr && q.rdy && hwdata[F_WCS+1] && !frame_src_active && !ev_f
    |=> !q.wcs[1])
    else $error("frame cause not cleared");
  a_w1c_zero: assert property (wr_pwr && !hwdata[F_WCS] && q.wcs[0]
    |=> q.wcs[0])
    else $error("cause cleared by a zero");
  a_src_frame: assert property (frame_src_active && q.wcs[1]
    |=> q.wcs[1])
    else $error("frame cause cleared while source active");
  a_pulse_start: assert property (q.tstart && q.act
    |=> busy)
    else $error("pulse timer not started");
  a_static_pin: assert property (q.act && !q.pulse && q.buf_pp && !q.dp_wr
    |=> wake_pin_o == q.pol)
    else $error("static wake level wrong");
  a_idle_pin: assert property (!q.act && q.buf_pp && !q.dp_wr
    |=> wake_pin_o == !q.pol)
    else $error("idle wake level wrong");
  a_pp_oe: assert property (q.buf_pp && !q.dp_wr
    |=> wake_pin_oe == q.oe)
    else $error("push-pull enable wrong");
  a_od_idle: assert property (!q.buf_pp && !q.act && !q.dp_wr
    |=> !wake_pin_oe)
    else $error("open drain driven while idle");
  a_act_drop: assert property (q.act && !ev_e && !ev_f && !q.dp_wr
    && !((q.wcs[0] & q.ede) | (q.wcs[1] & q.wfe)) |=> !q.act)
    else $error("wake output kept without enabled cause");
  a_irq_oe: assert property ((ev_e || ev_f) && !q.oe && q.imask[INT_WAKE] && !q.dp_wr
    |=> wake_irq)
    else $error("interrupt gated by output enable");
  a_irq_mask: assert property (q.imask == '0 && !q.dp_wr
    |=> !wake_irq)
    else $error("interrupt raised while masked");
  a_ready_rise: assert property (q.ph == PH_STABLE && q.stab <= 16'h0001
    |=> device_ready)
    else $error("ready not set after settling");
  a_ready_wait: assert property (q.ph == PH_STABLE && q.stab > 16'h0001
    |=> !device_ready)
    else $error("ready set before settling");
  a_rd_ready: assert property (ap && !hwrite && haddr[7:0] == A_PWR_CTL
    |=> hrdata[F_RDY] == $past(q.rdy) && hrdata[F_PSS+:2] == $past(q.pss))
    else $error("power control read wrong");
  a_rd_early: assert property (ap && !hwrite && haddr[7:0] == A_INT_STS && !q.rdy
    |=> hrdata == 32'h0000_0000)
    else $error("status readable before ready");
  a_mask_early: assert property (q.dp_wr && q.dp_addr == A_INT_MASK && !q.rdy
    |=> q.imask == $past(q.imask))
    else $error("mask written before ready");
  a_cfg_write: assert property (q.dp_wr && q.dp_addr == A_HARDWARE_CONFIG_REGISTER
    |=> q.hwcfg == $past(hwdata))
    else $error("config write lost");
  a_sleep_enter: assert property (wr_pwr && q.ph == PH_RUN && hwdata[F_PSS+:2] == PSS_FRAME
    |=> power_state == PSS_FRAME && !device_ready)
    else $error("sleep state not entered");
endmodule
